// File: iep_pkg.sv
// Package for the interrupt enable and priority block
package iep_pkg;
	localparam int IEP_NUM_SRC = 7;
	localparam logic [7:0] IEP_ADDR_ENABLE = 8'ha8;
	localparam logic [7:0] IEP_ADDR_LEVEL = 8'hb8;
	localparam logic [7:0] IEP_ENABLE_RESET = 8'h00;
	localparam logic [7:0] IEP_LEVEL_RESET = 8'h00;
	localparam int IEP_GATE_BIT = 7;
	localparam int IEP_CONV_BIT = 6;
	localparam int IEP_TMR2_BIT = 5;
	localparam int IEP_UART_BIT = 4;
	localparam int IEP_TMR1_BIT = 3;
	localparam int IEP_PIN1_BIT = 2;
	localparam int IEP_TMR0_BIT = 1;
	localparam int IEP_PIN0_BIT = 0;
	localparam logic [2:0] IEP_NO_SRC = 3'h7;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} iep_sfr_req_t;

	typedef struct packed {
		logic valid;
		logic high;
		logic [2:0] src;
	} iep_irq_req_t;
endpackage

// File: iep_ctrl.sv
// Interrupt enable and two-level priority controller
// What this block does
// [RULE1] Accept requests from the sources and give each one of two levels.
// [RULE2] Enable bit 7 is a master gate; clear blocks every source.
// [RULE3] Enable bit 6 gates the converter-complete request.
// [RULE4] Enable bit 5 gates the timer two request.
// [RULE5] Enable bit 4 gates the serial port request.
// [RULE6] Enable bit 3 gates the timer one request.
// [RULE7] Enable bit 2 gates the second pin request.
// [RULE8] Enable bit 1 gates the timer zero request.
// [RULE9] Enable bit 0 gates the first pin request.
// [RULE10] Level bits 6..0 map to sources in order; 1 is high, 0 low.
// [RULE11] Level bit 7 does nothing; any written value is harmless.
// [RULE12] Request only if pending, enabled and gated; high may preempt low.
module iep_ctrl
	import iep_pkg::*;
(
	input wire logic clk_sys, // Core clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire iep_sfr_req_t sfr_req, // Register access from the core
	output logic [7:0] sfr_rdata, // Read data, one cycle after rd
	input wire logic [IEP_NUM_SRC-1:0] pending, // Source flags, same clock
	input wire logic service_start, // Core enters the presented vector
	input wire logic service_end, // Core returns from an interrupt
	output iep_irq_req_t irq_req, // Request to the core
	output logic [1:0] in_service // Levels now being serviced
);
	logic [7:0] interrupt_enable;
	logic [7:0] interrupt_level_select;
	logic [IEP_NUM_SRC-1:0] armed;
	logic [1:0] next_in_service;
	logic [1:0] sfr_hit;
	iep_irq_req_t next_irq_req;
	// Check-only copies of the arbiter inputs one cycle back
	logic [IEP_NUM_SRC-1:0] armed_q;
	logic [IEP_NUM_SRC-1:0] level_q;

	// Gate and enable bits share one byte, so only seven sources fit
	if (IEP_NUM_SRC != 7) begin : g_src_check
		$error("iep_ctrl serves exactly seven gated sources");
	end

	// Decode shared by the write and read paths
	function automatic logic [1:0] sfr_select(input logic [7:0] addr);
		sfr_select = {addr == IEP_ADDR_LEVEL, addr == IEP_ADDR_ENABLE};
	endfunction

	assign sfr_hit = sfr_select(sfr_req.addr);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			interrupt_enable <= IEP_ENABLE_RESET;
			interrupt_level_select <= IEP_LEVEL_RESET;
		end else if (sfr_req.wr) begin
			if (sfr_hit[0])
				interrupt_enable <= sfr_req.wdata;
			// Bit 7 is stored but never steers anything
			if (sfr_hit[1])
				interrupt_level_select <= sfr_req.wdata; // see [RULE11]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			sfr_rdata <= 8'h00;
		else if (sfr_req.rd && sfr_hit[0])
			sfr_rdata <= interrupt_enable;
		else if (sfr_req.rd && sfr_hit[1])
			sfr_rdata <= interrupt_level_select;
		else
			sfr_rdata <= 8'h00;
	end

	// Per-source gate, then master gate
	always_comb begin
		armed = pending & interrupt_enable[IEP_NUM_SRC-1:0]; // see [RULE3] see [RULE4] see [RULE5]
		// Bits 3..0 likewise: see [RULE6] see [RULE7] see [RULE8] see [RULE9]
		if (!interrupt_enable[IEP_GATE_BIT])
			armed = '0; // see [RULE2]
	end

	// Lowest index wins inside a level, high level first
	always_comb begin
		next_irq_req = '{valid: 1'b0, high: 1'b0, src: IEP_NO_SRC};
		for (int i = IEP_NUM_SRC - 1; i >= 0; i--) begin
			if (armed[i] && !interrupt_level_select[i] && next_in_service == 2'b00)
				next_irq_req = '{valid: 1'b1, high: 1'b0, src: 3'(i)}; // see [RULE12]
		end
		for (int i = IEP_NUM_SRC - 1; i >= 0; i--) begin
			if (armed[i] && interrupt_level_select[i] && !next_in_service[1])
				next_irq_req = '{valid: 1'b1, high: 1'b1, src: 3'(i)}; // see [RULE10] see [RULE1]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			irq_req <= '{valid: 1'b0, high: 1'b0, src: IEP_NO_SRC};
		else
			irq_req <= next_irq_req;
	end

	// Service state as it stands after this edge; the arbiter looks at it
	// so that a request the core has just taken is withdrawn at once
	always_comb begin
		next_in_service = in_service;
		if (service_start && irq_req.valid)
			next_in_service[irq_req.high] = 1'b1; // see [RULE12]
		else if (service_end) begin
			// Two-level nesting: end of service releases the highest active level
			if (in_service[1])
				next_in_service[1] = 1'b0;
			else
				next_in_service[0] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			in_service <= 2'b00;
		else
			in_service <= next_in_service;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			armed_q <= '0;
			level_q <= '0;
		end else begin
			armed_q <= armed;
			level_q <= interrupt_level_select[IEP_NUM_SRC-1:0];
		end
	end

	// Gating: master bit first, then one enable per source
	a_master_gate: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE2]
		!interrupt_enable[IEP_GATE_BIT] |=> !irq_req.valid)
		else $error("request presented while master gate clear");
	a_conv_enable: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE3]
		!interrupt_enable[IEP_CONV_BIT] |=> !(irq_req.valid && irq_req.src == 3'(IEP_CONV_BIT)))
		else $error("converter request while its enable is clear");
	a_tmr2_enable: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE4]
		!interrupt_enable[IEP_TMR2_BIT] |=> !(irq_req.valid && irq_req.src == 3'(IEP_TMR2_BIT)))
		else $error("timer two request while its enable is clear");
	a_uart_enable: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE5]
		!interrupt_enable[IEP_UART_BIT] |=> !(irq_req.valid && irq_req.src == 3'(IEP_UART_BIT)))
		else $error("serial port request while its enable is clear");
	a_tmr1_enable: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE6]
		!interrupt_enable[IEP_TMR1_BIT] |=> !(irq_req.valid && irq_req.src == 3'(IEP_TMR1_BIT)))
		else $error("timer one request while its enable is clear");
	a_pin1_enable: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE7]
		!interrupt_enable[IEP_PIN1_BIT] |=> !(irq_req.valid && irq_req.src == 3'(IEP_PIN1_BIT)))
		else $error("second pin request while its enable is clear");
	a_tmr0_enable: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE8]
		!interrupt_enable[IEP_TMR0_BIT] |=> !(irq_req.valid && irq_req.src == 3'(IEP_TMR0_BIT)))
		else $error("timer zero request while its enable is clear");
	a_pin0_enable: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE9]
		!interrupt_enable[IEP_PIN0_BIT] |=> !(irq_req.valid && irq_req.src == 3'(IEP_PIN0_BIT)))
		else $error("first pin request while its enable is clear");
	a_source_enable: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE12]
		irq_req.valid |-> armed_q[irq_req.src])
		else $error("request from a disabled or idle source");
	a_idle_src: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE12]
		!irq_req.valid |-> irq_req.src == IEP_NO_SRC)
		else $error("idle request carries a source number");

	// Levels and nesting
	a_level_match: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE10]
		irq_req.valid |-> irq_req.high == level_q[irq_req.src])
		else $error("request level differs from level bit");
	a_no_preempt_high: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE12]
		in_service[1] |-> !irq_req.valid)
		else $error("request during high-level service");
	a_low_waits: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE12]
		in_service[0] && irq_req.valid |-> irq_req.high)
		else $error("low request during low-level service");
	a_high_first: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE1]
		((armed & interrupt_level_select[6:0]) != 0) && in_service == 2'b00
		&& !service_start |=> irq_req.valid && irq_req.high)
		else $error("high request not chosen first");
	a_armed_serves: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE12]
		armed != 0 && in_service == 2'b00 && !service_start
		|=> irq_req.valid)
		else $error("armed source not presented");
	a_take_high: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE12]
		service_start && irq_req.valid && irq_req.high |=> in_service[1])
		else $error("taken high request not marked in service");
	a_take_low: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE12]
		service_start && irq_req.valid && !irq_req.high |=> in_service[0])
		else $error("taken low request not marked in service");
	a_start_wins: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE12]
		service_start && irq_req.valid && service_end |=> in_service != 2'b00)
		else $error("return beat a simultaneous vector entry");

	// Register access
	a_bit7_inert: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE11]
		$changed(interrupt_level_select[7]) && $stable(interrupt_level_select[6:0])
		&& $stable(armed) && $stable(next_in_service) |=> $stable(irq_req))
		else $error("level bit 7 changed the request");
	a_read_back: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE2]
		sfr_req.rd && sfr_req.addr == IEP_ADDR_ENABLE |=> sfr_rdata == $past(interrupt_enable))
		else $error("enable register read back wrong");
	a_level_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE11]
		sfr_req.rd && sfr_req.addr == IEP_ADDR_LEVEL |=> sfr_rdata == $past(interrupt_level_select))
		else $error("level register read back wrong");
	a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE10]
		!sfr_req.rd |=> sfr_rdata == 8'h00)
		else $error("read data not cleared without a read");

	c_high_req: cover property (@(posedge clk_sys) disable iff (!rst_n)
		irq_req.valid && irq_req.high);
	c_low_req: cover property (@(posedge clk_sys) disable iff (!rst_n)
		irq_req.valid && !irq_req.high);
	c_preempt: cover property (@(posedge clk_sys) disable iff (!rst_n)
		in_service == 2'b01 && irq_req.valid && irq_req.high);
	c_nested: cover property (@(posedge clk_sys) disable iff (!rst_n) in_service == 2'b11);
	c_low_release: cover property (@(posedge clk_sys) disable iff (!rst_n)
		in_service == 2'b01 ##1 in_service == 2'b00);
endmodule

// File: iep_core_model.sv
// Core model that takes presented interrupt requests
module iep_core_model
	import iep_pkg::*;
(
	input wire logic clk_sys, // Core clock
	input wire iep_irq_req_t irq_req, // Request from block
	input wire logic take_en, // Bench lets core take
	output logic service_start // Vector entry pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	initial service_start = 1'b0;
	// One pulse per request; the guard stops a second take of a stale one
	always @(posedge clk_sys) begin
		service_start <= take_en && irq_req.valid && !service_start;
	end
endmodule

// File: interrupt_enable_priority_test.sv
// Self-checking bench for the interrupt enable and priority block
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin num_errors++; \
$display("Error %s exp %h got %h", n, e, s); end end
module interrupt_enable_priority_test
	import iep_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rst_n, service_start, service_end, take_en;
	iep_sfr_req_t sfr_req;
	iep_irq_req_t irq_req;
	logic [7:0] sfr_rdata;
	logic [6:0] pending;
	logic [1:0] in_service;
	int num_errors = 0;
	int n_compared = 0;
	// Enable, level, pending, expected valid/high/src
	logic [27:0] rows [12] = '{
		{8'h81, 8'h00, 7'h01, 5'h10},
		{8'h7f, 8'h00, 7'h7f, 5'h07},
		{8'h80, 8'h00, 7'h7f, 5'h07},
		{8'hff, 8'h00, 7'h7f, 5'h10},
		{8'hff, 8'h20, 7'h7f, 5'h1d},
		{8'hc0, 8'h00, 7'h40, 5'h16},
		{8'ha0, 8'hff, 7'h20, 5'h1d},
		{8'h90, 8'h00, 7'h10, 5'h14},
		{8'h88, 8'h00, 7'h08, 5'h13},
		{8'h84, 8'h00, 7'h04, 5'h12},
		{8'h82, 8'h00, 7'h02, 5'h11},
		{8'hbf, 8'h00, 7'h40, 5'h07}};
	iep_ctrl i_iep_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .pending(pending), .service_start(service_start),
		.service_end(service_end), .irq_req(irq_req), .in_service(in_service));
	iep_core_model i_iep_core_model (.clk_sys(clk_sys), .irq_req(irq_req),
		.take_en(take_en), .service_start(service_start));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_req <= '{1'b1, 1'b0, a, d};
		tick(1);
		sfr_req <= '0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sfr_req <= '{1'b0, 1'b1, a, 8'h00};
		tick(1);
		sfr_req <= '0;
		@(negedge clk_sys);
		`CHK("sfr_rdata", e, sfr_rdata)
		tick(1);
	endtask
	task automatic end_sim;
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		tick(2000);
		num_errors++;
		end_sim;
	end
	initial begin
		{rst_n, service_end, take_en, pending, sfr_req} = '0;
		tick(20);
		rst_n <= 1'b1;
		tick(1);
		foreach (rows[i]) begin
			wr(IEP_ADDR_ENABLE, rows[i][27:20]);
			wr(IEP_ADDR_LEVEL, rows[i][19:12]);
			pending <= rows[i][11:5];
			tick(3);
			@(negedge clk_sys);
			`CHK("irq_req", rows[i][4:0], irq_req)
			tick(1);
			pending <= '0;
		end
		$display("Table test done");
		wr(IEP_ADDR_LEVEL, 8'h80);
		rd(IEP_ADDR_LEVEL, 8'h80);
		rd(IEP_ADDR_ENABLE, 8'hbf);
		rd(8'ha9, 8'h00);
		// Mid-run reset must clear both registers
		rst_n <= 1'b0;
		tick(2);
		rst_n <= 1'b1;
		tick(1);
		rd(IEP_ADDR_ENABLE, IEP_ENABLE_RESET);
		rd(IEP_ADDR_LEVEL, IEP_LEVEL_RESET);
		$display("Register test done");
		wr(IEP_ADDR_ENABLE, 8'hff);
		wr(IEP_ADDR_LEVEL, 8'h40);
		take_en <= 1'b1;
		pending <= 7'h01;
		tick(6);
		pending <= 7'h40;
		tick(6);
		@(negedge clk_sys);
		`CHK("in_service", 2'b11, in_service)
		tick(1);
		take_en <= 1'b0;
		pending <= 7'h01;
		tick(3);
		@(negedge clk_sys);
		`CHK("irq_req", 5'h07, irq_req)
		tick(1);
		service_end <= 1'b1;
		tick(1);
		service_end <= 1'b0;
		tick(3);
		@(negedge clk_sys);
		`CHK("in_service", 2'b01, in_service)
		`CHK("irq_req", 5'h07, irq_req)
		tick(1);
		service_end <= 1'b1;
		tick(1);
		service_end <= 1'b0;
		tick(3);
		@(negedge clk_sys);
		`CHK("in_service", 2'b00, in_service)
		`CHK("irq_req", 5'h10, irq_req)
		$display("Preemption test done");
		end_sim;
	end
endmodule
